// File: rtl/fls_map.svh
// Register offsets, field positions, reset values and timing counts of the link supervisor
`ifndef FLS_MAP_SVH
`define FLS_MAP_SVH
`define FLS_OFF_CTRL 8'h00
`define FLS_OFF_STATUS 8'h04
`define FLS_OFF_MASK 8'h08
`define FLS_OFF_PEER_SEL 8'h0c
`define FLS_OFF_SCAN_USE 8'h10
`define FLS_OFF_HB_PERIOD 8'h14
`define FLS_OFF_LINK_STAT 8'h18
`define FLS_CTRL_FAULT_RESET 0
`define FLS_CTRL_D2D_CAP 1
`define FLS_ST_OWN 0
`define FLS_ST_INIT 1
`define FLS_ST_MASTER 2
`define FLS_ST_PEER 3
`define FLS_NUM_PEERS 4
`define FLS_NUM_SCAN 10
`define FLS_HB_IN_BIT 2
`define FLS_HB_OUT_BIT 0
`define FLS_HB_PERIOD_RST 32'h000f4240
`define FLS_CTRL_RST 32'h00000002
`endif

// File: rtl/fls_pkg.sv
// Types of the fieldbus link supervisor
package fls_pkg;
    typedef enum logic [1:0] {
        FLS_INIT_WAIT = 2'b00,
        FLS_INIT_RUN = 2'b01,
        FLS_INIT_DONE = 2'b10
    } fls_init_state_t;
    typedef logic [3:0] fls_peer_sel_t;
endpackage

// File: rtl/fls_hb_watch.sv
// Heartbeat echo and stall watchdog
`timescale 1ns/10ps
`include "fls_map.svh"
module fls_hb_watch (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [31:0] period_i,
    input wire logic [15:0] seq_in_word_i,
    output logic [15:0] seq_out_word_o,
    output logic stall_o
);
    logic hb_prev_reg;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    wire hb_rx = seq_in_word_i[`FLS_HB_IN_BIT];
    wire hb_edge = hb_rx ^ hb_prev_reg;
    wire expired = (cnt_reg >= period_i);
    ////////////////////////////////////////////////////////////////
    // Counter restarts on every heartbeat transition
    assign cnt_next = (hb_edge || !enable_i) ? 32'h00000000 :
                      (expired ? cnt_reg : cnt_reg + 32'h00000001);
    assign stall_o = enable_i && expired;
    // Echo register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hb_prev_reg <= 1'b0;
            cnt_reg <= 32'h00000000;
            seq_out_word_o <= 16'h0000;
        end else begin
            hb_prev_reg <= hb_rx;
            cnt_reg <= cnt_next;
            seq_out_word_o <= {15'h0000, hb_rx} << `FLS_HB_OUT_BIT;
        end
    end
endmodule // fls_hb_watch

// File: rtl/fls_supervisor.sv
// Fieldbus link supervisor with Wishbone register file
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "fls_map.svh"
module fls_supervisor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic board_wdt_fault_i,
    input wire logic board_hw_fault_i,
    input wire logic init_done_i,
    input wire logic init_error_i,
    input wire logic own_online_i,
    input wire logic master_online_i,
    input wire logic master_healthy_i,
    input wire logic master_scan_update_i,
    input wire logic [15:0] online_map_i,
    input wire logic [15:0] healthy_map_i,
    input wire logic [15:0] update_map_i,
    input wire logic [15:0] serial_seq_in_word_i,
    output logic [15:0] serial_seq_out_word_o,
    output logic own_station_fault_o,
    output logic init_fault_o,
    output logic master_link_fault_o,
    output logic peer_link_fault_o,
    output logic irq_o
);
    import fls_pkg::*;

    logic [31:0] ctrl_reg;
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic [3:0] mask_reg;
    logic [15:0] peer_sel_reg;
    logic [9:0] scan_use_reg;
    logic [31:0] hb_period_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic online_seen_reg;
    fls_init_state_t init_state_reg;
    fls_init_state_t init_state_next;
    logic hb_stall;

    ////////////////////////////////////////////////////////////////
    // Station status by number; station 0 is never selected
    function automatic logic peer_bad(input fls_peer_sel_t sel, input logic [15:0] onl,
                                      input logic [15:0] hlt, input logic [15:0] upd);
        peer_bad = (sel != 4'h0) && !(onl[sel] && hlt[sel] && upd[sel]);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wire wr_ctrl = bus_wr && (wb_adr_i == `FLS_OFF_CTRL);
    wire wr_status = bus_wr && (wb_adr_i == `FLS_OFF_STATUS);
    wire wr_mask = bus_wr && (wb_adr_i == `FLS_OFF_MASK);
    wire wr_peer = bus_wr && (wb_adr_i == `FLS_OFF_PEER_SEL);
    wire wr_scan = bus_wr && (wb_adr_i == `FLS_OFF_SCAN_USE);
    wire wr_per = bus_wr && (wb_adr_i == `FLS_OFF_HB_PERIOD);
    wire fault_reset = wr_ctrl && wb_dat_i[`FLS_CTRL_FAULT_RESET];
    wire d2d_cap = ctrl_reg[`FLS_CTRL_D2D_CAP];

    ////////////////////////////////////////////////////////////////
    // Detection enables
    wire scan_any_used = |scan_use_reg;
    wire peers_sel = |peer_sel_reg;
    wire det_en = scan_any_used;

    ////////////////////////////////////////////////////////////////
    // Initialisation supervision
    always_comb begin
        init_state_next = init_state_reg;
        case (init_state_reg)
            FLS_INIT_WAIT: if (init_done_i) init_state_next = FLS_INIT_RUN;
            FLS_INIT_RUN: if (own_online_i) init_state_next = FLS_INIT_DONE;
            FLS_INIT_DONE: init_state_next = FLS_INIT_DONE;
            default: init_state_next = FLS_INIT_WAIT;
        endcase
    end
    // Init done but not online, or processing error
    wire ev_init = det_en && (init_error_i ||
                   (init_state_reg == FLS_INIT_RUN && !own_online_i));

    ////////////////////////////////////////////////////////////////
    // Fault events
    wire board_fail = board_wdt_fault_i || board_hw_fault_i;
    wire ev_own = det_en && online_seen_reg && board_fail;
    wire link_bad = !own_online_i || !master_online_i || !master_healthy_i ||
                    !master_scan_update_i;
    wire ev_master = det_en && online_seen_reg && (link_bad || hb_stall);
    wire [3:0] peer_bad_vec;
    assign peer_bad_vec[0] = peer_bad(peer_sel_reg[3:0], online_map_i, healthy_map_i,
                                      update_map_i);
    assign peer_bad_vec[1] = peer_bad(peer_sel_reg[7:4], online_map_i, healthy_map_i,
                                      update_map_i);
    assign peer_bad_vec[2] = peer_bad(peer_sel_reg[11:8], online_map_i, healthy_map_i,
                                      update_map_i);
    assign peer_bad_vec[3] = peer_bad(peer_sel_reg[15:12], online_map_i, healthy_map_i,
                                      update_map_i);
    wire ev_peer = det_en && peers_sel && d2d_cap && online_seen_reg &&
                   (|peer_bad_vec);
    wire [3:0] events = {ev_peer, ev_master, ev_init, ev_own};

    ////////////////////////////////////////////////////////////////
    // Sticky status: set wins over clear and over fault reset
    assign status_next = events |
        (status_reg & ~(wr_status ? wb_dat_i[3:0] : 4'h0) & ~{4{fault_reset}});

    ////////////////////////////////////////////////////////////////
    // Read mux
    wire [31:0] rd_mux =
        (wb_adr_i == `FLS_OFF_CTRL) ? ctrl_reg :
        (wb_adr_i == `FLS_OFF_STATUS) ? {28'h0000000, status_reg} :
        (wb_adr_i == `FLS_OFF_MASK) ? {28'h0000000, mask_reg} :
        (wb_adr_i == `FLS_OFF_PEER_SEL) ? {16'h0000, peer_sel_reg} :
        (wb_adr_i == `FLS_OFF_SCAN_USE) ? {22'h000000, scan_use_reg} :
        (wb_adr_i == `FLS_OFF_HB_PERIOD) ? hb_period_reg :
        (wb_adr_i == `FLS_OFF_LINK_STAT) ? {28'h0000000, hb_stall, online_seen_reg,
                                            init_state_reg} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////
    // Heartbeat echo and stall supervision
    fls_hb_watch u_hb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(det_en && online_seen_reg),
        .period_i(hb_period_reg),
        .seq_in_word_i(serial_seq_in_word_i),
        .seq_out_word_o(serial_seq_out_word_o),
        .stall_o(hb_stall)
    );

    ////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `FLS_CTRL_RST;
            mask_reg <= 4'h0;
            peer_sel_reg <= 16'h0000;
            scan_use_reg <= 10'h000;
            hb_period_reg <= `FLS_HB_PERIOD_RST;
        end else begin
            if (wr_ctrl) ctrl_reg <= {30'h00000000, wb_dat_i[`FLS_CTRL_D2D_CAP], 1'b0};
            if (wr_mask) mask_reg <= wb_dat_i[3:0];
            if (wr_peer) peer_sel_reg <= wb_dat_i[15:0];
            if (wr_scan) scan_use_reg <= wb_dat_i[9:0];
            if (wr_per) hb_period_reg <= wb_dat_i;
        end
    end

    // Status, state and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 4'h0;
            init_state_reg <= FLS_INIT_WAIT;
            online_seen_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            status_reg <= status_next;
            init_state_reg <= init_state_next;
            online_seen_reg <= online_seen_reg || (own_online_i && init_done_i);
            ack_reg <= bus_req;
            rdata_reg <= bus_req ? rd_mux : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign own_station_fault_o = status_reg[`FLS_ST_OWN];
    assign init_fault_o = status_reg[`FLS_ST_INIT];
    assign master_link_fault_o = status_reg[`FLS_ST_MASTER];
    assign peer_link_fault_o = status_reg[`FLS_ST_PEER];
    assign irq_o = |(status_reg & mask_reg);
endmodule // fls_supervisor

// File: tb/fls_supervisor_assertions.sv
// Port checker of the link supervisor
`timescale 1ns/10ps
`include "fls_map.svh"
module fls_supervisor_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic board_wdt_fault_i,
    input wire logic init_done_i,
    input wire logic init_error_i,
    input wire logic own_online_i,
    input wire logic master_online_i,
    input wire logic [15:0] serial_seq_in_word_i,
    input wire logic [15:0] serial_seq_out_word_o,
    input wire logic own_station_fault_o,
    input wire logic init_fault_o,
    input wire logic master_link_fault_o,
    input wire logic peer_link_fault_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
logic scan_on_reg;
logic seen_reg;
sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
// Shadows of scan usage and of online seen
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        scan_on_reg <= 1'b0;
        seen_reg <= 1'b0;
    end else begin
        if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] &&
                wb_adr_i == `FLS_OFF_SCAN_USE) begin
            scan_on_reg <= |wb_dat_i[9:0];
        end
        if (own_online_i && init_done_i) begin
            seen_reg <= 1'b1;
        end
    end
end
AST_ACK_ONE: assert property (s_req |=> wb_ack_o) else $error("ack late");
AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
AST_HB_ECHO: assert property (!$past(rst_i) |->
    serial_seq_out_word_o[0] == $past(serial_seq_in_word_i[2])) else $error("echo wrong");
AST_HB_ZERO: assert property (serial_seq_out_word_o[15:1] == 15'h0)
    else $error("spare bits set");
AST_INIT: assert property (scan_on_reg && init_error_i |=> init_fault_o)
    else $error("init fault missing");
AST_OWN: assert property (scan_on_reg && seen_reg && board_wdt_fault_i |=>
    own_station_fault_o) else $error("own fault missing");
AST_MASTER: assert property (scan_on_reg && seen_reg && !master_online_i |=>
    master_link_fault_o) else $error("link fault missing");
AST_QUIET: assert property (!scan_on_reg |=> !$rose(|{own_station_fault_o,
    init_fault_o, master_link_fault_o, peer_link_fault_o})) else $error("fault while unused");
AST_LATCH: assert property ($fell(own_station_fault_o) || $fell(init_fault_o) ||
    $fell(master_link_fault_o) || $fell(peer_link_fault_o) |->
    $past(wb_cyc_i && wb_stb_i && wb_we_i)) else $error("fault dropped alone");
endmodule // fls_supervisor_assertions
bind fls_supervisor fls_supervisor_assertions u_fls_supervisor_assertions (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
    .board_wdt_fault_i, .init_done_i, .init_error_i, .own_online_i, .master_online_i,
    .serial_seq_in_word_i, .serial_seq_out_word_o, .own_station_fault_o, .init_fault_o,
    .master_link_fault_o, .peer_link_fault_o);

// File: tb/fls_master_model.sv
// Master station model: heartbeat source and echo watch
`timescale 1ns/10ps
module fls_master_model #(parameter int LIMIT = 12) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [15:0] echo_word_i,
    output logic [15:0] seq_word_o,
    output logic drive_error_o
);
logic [7:0] cnt_reg;
logic [7:0] diff_reg;
logic hb_reg;
// Spare bits change every cycle
assign seq_word_o = {cnt_reg, ~cnt_reg[4:0], hb_reg, cnt_reg[1:0]};
// Toggle heartbeat, time echo mismatch
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        cnt_reg <= 8'h00;
        diff_reg <= 8'h00;
        hb_reg <= 1'b0;
        drive_error_o <= 1'b0;
    end else begin
        cnt_reg <= cnt_reg + 8'h01;
        hb_reg <= hb_reg ^ (run_i && cnt_reg[2:0] == 3'h7);
        diff_reg <= (echo_word_i[0] != hb_reg) ? diff_reg + 8'h01 : 8'h00;
        drive_error_o <= drive_error_o || diff_reg > LIMIT;
    end
end
endmodule // fls_master_model

// File: tb/fls_supervisor_tb.sv
// Testbench of the link supervisor
`timescale 1ns/10ps
`include "fls_map.svh"
module fls_supervisor_tb;
logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
logic board_wdt_fault_i = 1'b0, board_hw_fault_i = 1'b0, init_done_i = 1'b0, init_error_i = 1'b0;
logic run = 1'b1, wb_ack_o, irq_o, derr;
logic [3:0] good = 4'h7;
logic [7:0] wb_adr_i = 8'h00;
logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
logic [2:0][15:0] maps = {3{16'hffff}};
logic [15:0] serial_seq_in_word_i, serial_seq_out_word_o;
logic [3:0] flt;
int errors = 0, comparisons = 0, cycles = 0;
logic [31:0] rv [8] = '{`FLS_CTRL_RST, 0, 0, 0, 0, `FLS_HB_PERIOD_RST, 0, 0};
always #2.5 clk_i = ~clk_i;
fls_supervisor u_fls_supervisor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .board_wdt_fault_i, .board_hw_fault_i,
    .init_done_i, .init_error_i, .own_online_i(good[3]), .master_online_i(good[2]),
    .master_healthy_i(good[1]), .master_scan_update_i(good[0]), .online_map_i(maps[0]),
    .healthy_map_i(maps[1]), .update_map_i(maps[2]), .serial_seq_in_word_i,
    .serial_seq_out_word_o, .own_station_fault_o(flt[0]), .init_fault_o(flt[1]),
    .master_link_fault_o(flt[2]), .peer_link_fault_o(flt[3]), .irq_o);
fls_master_model u_fls_master_model (.clk_i, .rst_i, .run_i(run),
    .echo_word_i(serial_seq_out_word_o), .seq_word_o(serial_seq_in_word_i), .drive_error_o(derr));
task automatic complete_run();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
        errors++;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
// One classic cycle; holds until ack is sampled
task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && cycles < 20000);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk_i);
endtask
// Cycle ceiling
always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
        errors++;
        complete_run();
    end
end
initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rv[i]) begin
        xfer(8'(i * 4), 1'b0, 0);
        check(rd, rv[i]);
    end
    $display("end of reset test");
    init_error_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(flt, 4'h0);
    xfer(`FLS_OFF_MASK, 1'b1, 32'hf);
    xfer(`FLS_OFF_SCAN_USE, 1'b1, 32'h200);
    check({irq_o, flt}, 5'h12);
    init_error_i <= 1'b0;
    init_done_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    good <= 4'hf;
    xfer(`FLS_OFF_STATUS, 1'b1, 32'h0);
    check(rd, 32'h2);
    xfer(`FLS_OFF_STATUS, 1'b1, 32'hf);
    xfer(`FLS_OFF_LINK_STAT, 1'b0, 0);
    check({27'h0000000, irq_o, flt}, 32'h0);
    check(rd, 32'h6);
    $display("end of init test");
    for (int k = 0; k < 2; k++) begin
        {board_hw_fault_i, board_wdt_fault_i} <= 2'(1 << k);
        @(posedge clk_i);
        {board_hw_fault_i, board_wdt_fault_i} <= 2'b00;
        repeat (3) @(posedge clk_i);
        check(flt, 4'h1);
        xfer(`FLS_OFF_STATUS, 1'b1, 32'h1);
    end
    for (int k = 0; k < 4; k++) begin
        good <= 4'hf ^ 4'(1 << k);
        repeat (2) @(posedge clk_i);
        good <= 4'hf;
        xfer(`FLS_OFF_STATUS, 1'b1, 32'h0);
        check(flt, 4'h4);
        xfer(`FLS_OFF_STATUS, 1'b1, 32'h4);
    end
    $display("end of fault test");
    xfer(`FLS_OFF_HB_PERIOD, 1'b1, 32'd20);
    repeat (60) @(posedge clk_i);
    check({derr, flt}, 5'h00);
    run <= 1'b0;
    repeat (40) @(posedge clk_i);
    check(flt, 4'h4);
    run <= 1'b1;
    repeat (12) @(posedge clk_i);
    xfer(`FLS_OFF_PEER_SEL, 1'b1, 32'h5000);
    for (int k = 0; k < 4; k++) begin
        xfer(`FLS_OFF_CTRL, 1'b1, {30'h0, k < 3, 1'b1});
        check(flt, 4'h0);
        maps[k % 3][5] <= 1'b0;
        repeat (2) @(posedge clk_i);
        maps <= {3{16'hffff}};
        repeat (2) @(posedge clk_i);
        check(flt, (k < 3) ? 4'h8 : 4'h0);
    end
    $display("end of peer test");
    complete_run();
end
endmodule // fls_supervisor_tb
